// >>> irap_checker.sv
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Wire checks on the link between the two ends
// ------------------------------------------------------------
module irap_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic sda_d_oe,
	input wire logic scl,
	input wire logic sda
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// Start and stop framing events
	sequence start_seq;
		scl && $fell(sda);
	endsequence
	sequence stop_seq;
		scl && $rose(sda);
	endsequence
	// Clock pulled low shortly after a start
	sequence clk_low_after_start;
		scl [*5] ##[1:4] !scl;
	endsequence

	AST_START_FORM: assert property (start_seq |-> clk_low_after_start)
		else $error("start not followed by clock low");
	AST_STOP_IDLE: assert property (stop_seq |-> (scl && sda && !sda_d_oe) [*4])
		else $error("bus not idle after stop");
	// Target moves data only while clock is low, so never frames
	AST_TGT_RISE: assert property ($rose(sda_d_oe) |-> !scl)
		else $error("target grabbed data with clock high");
	AST_TGT_FALL: assert property ($fell(sda_d_oe) |-> !scl)
		else $error("target let go of data with clock high");
	AST_TGT_HOLD: assert property ($rose(sda_d_oe) |-> sda_d_oe [*8])
		else $error("target drive too short");
	// A stuck target would hang the link for good
	AST_TGT_BOUND: assert property (sda_d_oe |-> ##[0:600] !sda_d_oe)
		else $error("target holds data line too long");
	// Pulse widths keep the bit rate inside fast mode
	AST_SCL_HIGH_MIN: assert property ($rose(scl) |-> scl [*8])
		else $error("clock high too short");
	AST_SCL_LOW_MIN: assert property ($fell(scl) |-> (!scl) [*8])
		else $error("clock low too short");
endmodule // irap_checker

`default_nettype wire

// >>> irap_controller.sv
`timescale 1ns/100ps
`default_nettype none

module irap_controller
	import irap_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	irap_i2c_if.controller    bus,
	input  wire logic         cmd_valid,
	output var  logic         cmd_ready,
	input  wire logic         cmd_read,
	input  wire logic [6:0]   cmd_dev,
	input  wire logic [7:0]   cmd_reg,
	input  wire logic [15:0]  cmd_wdata,
	input  wire logic [3:0]   cmd_words,
	output var  logic         rd_valid,
	input  wire logic         rd_ready,
	output var  logic [15:0]  rd_data,
	output var  logic         done,
	output var  logic         nack_err
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [1:0]      sda_p;
		irap_ctl_state_t st;
		logic [3:0]      div;
		logic [1:0]      q;
		logic [3:0]      bitn;
		logic [5:0]      byten;
		logic            rd;
		logic [3:0]      words;
		logic [6:0]      dev;
		logic [7:0]      regn;
		logic [15:0]     wdata;
		logic [7:0]      sh;
		logic [7:0]      rx;
		logic [7:0]      hi;
		logic            ack;
		logic            scl_oe;
		logic            sda_oe;
		logic            cmd_ready;
		logic            rd_valid;
		logic [15:0]     rd_data;
		logic            done;
		logic            nack_err;
	} irap_ctl_reg_t;

	irap_ctl_reg_t state_reg;
	irap_ctl_reg_t state_next;

	// ----------------------------------------------------------------
	// Next state; start, bit and stop phases step once per quarter bit
	// ----------------------------------------------------------------
	always_comb begin
		logic            tick;
		logic            rxm;
		logic            last;
		logic [5:0]      nb;
		logic [7:0]      txb;
		irap_ctl_reg_t   r;
		irap_ctl_reg_t   n;
		r = state_reg;
		n = state_reg;
		txb = 8'h00;
		n.sda_p = {r.sda_p[0], bus.sda};
		n.done  = 1'b0;
		tick    = (r.div == QTR_CYC - 4'h1);
		n.div   = tick ? 4'h0 : r.div + 4'h1;
		rxm     = r.rd & (r.byten > 6'h2);
		last    = r.rd ? (r.byten == 6'(6'h2 + {r.words, 1'b0})) :
			(r.byten == 6'h3);
		nb      = r.byten + 6'h1;
		// Outgoing byte by position, words high byte first
		unique case (nb)
			6'h1:    txb = r.regn;
			6'h2:    txb = r.rd ? {r.dev, 1'b1} : r.wdata[15:8];
			6'h3:    txb = r.wdata[7:0];
			default: txb = 8'h00;
		endcase
		if (r.rd_valid && rd_ready)
			n.rd_valid = 1'b0;

		unique case (r.st)
			H_IDLE: begin
				n.cmd_ready = ~n.rd_valid;
				if (cmd_valid && r.cmd_ready) begin
					n.cmd_ready = 1'b0;
					n.rd        = cmd_read;
					n.dev       = cmd_dev;
					n.regn      = cmd_reg;
					n.wdata     = cmd_wdata;
					n.words     = (cmd_words == 4'h0) ? 4'h1 : cmd_words;
					n.byten     = 6'h0;
					n.nack_err  = 1'b0;
					n.sh        = {cmd_dev, 1'b0};
					n.st        = H_START;
					n.q         = 2'h0;
					n.div       = 4'h0;
				end
			end
			H_START: begin
				if (tick) begin
					n.q = r.q + 2'h1;
					unique case (r.q)
						2'h0: n.sda_oe = 1'b0;
						2'h1: n.scl_oe = 1'b0;
						2'h2: n.sda_oe = 1'b1;
						2'h3: begin
							n.scl_oe = 1'b1;
							n.bitn   = 4'h0;
							n.st     = H_BIT;
						end
					endcase
				end
			end
			H_BIT: begin
				if (tick) begin
					n.q = r.q + 2'h1;
					unique case (r.q)
						2'h0: begin
							// Data changes only while the clock is low
							if (r.bitn != 4'h8)
								n.sda_oe = rxm ? 1'b0 : ~r.sh[7];
							else
								n.sda_oe = rxm & ~last;
						end
						2'h1: n.scl_oe = 1'b0;
						2'h2: begin
							if (r.bitn != 4'h8) begin
								n.rx = {r.rx[6:0], r.sda_p[1]};
								n.sh = {r.sh[6:0], 1'b0};
							end else begin
								n.ack = ~r.sda_p[1];
							end
						end
						2'h3: begin
							n.scl_oe = 1'b1;
							n.bitn   = r.bitn + 4'h1;
							if (r.bitn == 4'h8) begin
								n.bitn = 4'h0;
								n.byten = nb;
								n.sh    = txb;
								if (!rxm && !r.ack) begin
									n.nack_err = 1'b1;
									n.st       = H_STOP;
								end else if (rxm && !r.byten[0]) begin
									n.rd_valid = 1'b1;
									n.rd_data  = {r.hi, r.rx};
									n.st       = last ? H_STOP : H_WAIT;
								end else if (last) begin
									n.st = H_STOP;
								end else if (r.rd && r.byten == 6'h1) begin
									n.st = H_START;
								end
								if (rxm)
									n.hi = r.rx;
							end
						end
					endcase
				end
			end
			H_WAIT: begin
				// Clock held low until the word is taken
				n.div = 4'h0;
				n.q   = 2'h0;
				if (!r.rd_valid)
					n.st = H_BIT;
			end
			H_STOP: begin
				if (tick) begin
					n.q = r.q + 2'h1;
					unique case (r.q)
						2'h0: n.sda_oe = 1'b1;
						2'h1: n.scl_oe = 1'b0;
						2'h2: n.sda_oe = 1'b0;
						2'h3: begin
							n.done = 1'b1;
							n.st   = H_IDLE;
						end
					endcase
				end
			end
		endcase
		state_next = n;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg       <= '0;
			state_reg.sda_p <= 2'h3;
			state_reg.st    <= H_IDLE;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus.scl_o    = 1'b0;
	assign bus.scl_oe   = state_reg.scl_oe;
	assign bus.sda_h_o  = 1'b0;
	assign bus.sda_h_oe = state_reg.sda_oe;
	assign cmd_ready    = state_reg.cmd_ready;
	assign rd_valid     = state_reg.rd_valid;
	assign rd_data      = state_reg.rd_data;
	assign done         = state_reg.done;
	assign nack_err     = state_reg.nack_err;

endmodule // irap_controller

`default_nettype wire

// >>> irap_i2c_if.sv
`timescale 1ns/100ps
`default_nettype none

// Two-wire bus; open-drain lines resolved from the enables
interface irap_i2c_if;
	logic scl_o;
	logic scl_oe;
	logic sda_h_o;
	logic sda_h_oe;
	logic sda_d_o;
	logic sda_d_oe;
	logic scl;
	logic sda;

	// Pull-ups win unless someone drives
	assign scl = scl_oe ? scl_o : 1'b1;
	assign sda = (sda_h_oe ? sda_h_o : 1'b1) & (sda_d_oe ? sda_d_o : 1'b1);

	modport target (
		input  scl,
		input  sda,
		output sda_d_o,
		output sda_d_oe
	);

	modport controller (
		input  scl,
		input  sda,
		output scl_o,
		output scl_oe,
		output sda_h_o,
		output sda_h_oe
	);
endinterface // irap_i2c_if

`default_nettype wire

// >>> irap_pkg.sv
package irap_pkg;

	// ----------------------------------------------------------------
	// Bus address and register map
	// ----------------------------------------------------------------
	localparam logic [6:0]  DEF_BUS_ADDR   = 7'h64;
	localparam logic [7:0]  REG_BUS_ADDR   = 8'h09;
	localparam logic [7:0]  REG_ADDR_KEY   = 8'h0D;
	localparam logic [7:0]  REG_SOFT_RST   = 8'h0F;
	localparam logic [7:0]  REG_PIN_BUF    = 8'h4F;
	localparam logic [7:0]  REG_HOLD_LO    = 8'h5F;
	localparam logic [7:0]  REG_FIFO       = 8'h60;
	localparam logic [7:0]  REG_HOLD_HI    = 8'h7F;
	localparam logic [7:0]  ADDR_UNLOCK    = 8'hAD;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int          BUS_ADDR_MSB   = 7;
	localparam int          BUS_ADDR_LSB   = 1;
	localparam int          UNLOCK_MSB     = 15;
	localparam int          UNLOCK_LSB     = 8;
	localparam int          SOFT_RST_BIT   = 0;
	localparam int          PIN_BUF_INT    = 1;
	localparam int          PIN_BUF_AUX    = 5;
	localparam int          KEY_INT_USE    = 0;
	localparam int          KEY_INT_LVL    = 1;
	localparam int          KEY_AUX_USE    = 2;
	localparam int          KEY_AUX_LVL    = 3;
	localparam logic [15:0] KEY_RST        = 16'h0000;
	localparam logic [15:0] PIN_BUF_RST    = 16'h0000;
	localparam logic [1:0]  FIFO_DEPTH     = 2'h2;

	// ----------------------------------------------------------------
	// Timing: quarter of one serial bit at the clock rate
	// ----------------------------------------------------------------
	localparam int          CLK_KHZ        = 10000;
	localparam int          QTR_NS         = 625;
	localparam logic [3:0]  QTR_CYC        =
		4'((QTR_NS * CLK_KHZ + 999999) / 1000000);

	// ----------------------------------------------------------------
	// State encodings
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		T_IDLE, T_ADDR, T_REG, T_WR, T_RD, T_SKIP
	} irap_tgt_phase_t;

	typedef enum logic [2:0] {
		H_IDLE, H_START, H_BIT, H_WAIT, H_STOP
	} irap_ctl_state_t;

endpackage

// >>> irap_target.sv
`timescale 1ns/100ps
`default_nettype none

module irap_target
	import irap_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rst_n,
	irap_i2c_if.target        bus,
	input  wire logic         int_pin,
	input  wire logic         aux_select_pin,
	input  wire logic         push_valid,
	input  wire logic [15:0]  push_data,
	output var  logic         push_ready,
	output var  logic         soft_reset,
	output var  logic [6:0]   bus_address
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [2:0]       scl_p;
		logic [2:0]       sda_p;
		logic [1:0]       int_p;
		logic [1:0]       aux_p;
		irap_tgt_phase_t  ph;
		logic [3:0]       bcnt;
		logic [7:0]       sh;
		logic [7:0]       tx;
		logic             bidx;
		logic [1:0]       widx;
		logic             mack;
		logic             oe;
		logic [7:0]       ptr;
		logic [7:0]       whi;
		logic [6:0]       addr;
		logic [15:0]      key;
		logic             key_armed;
		logic [15:0]      pin_buf;
		logic [1:0][15:0] mem;
		logic             wi;
		logic             ri;
		logic [1:0]       cnt;
		logic             ready;
		logic             srst;
	} irap_tgt_state_t;

	irap_tgt_state_t state_reg;
	irap_tgt_state_t state_next;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic         rise;
		logic         fall;
		logic         start_c;
		logic         stop_c;
		logic         push;
		logic         pop;
		logic         do_srst;
		logic         key_ok;
		logic [15:0]  word;
		logic [15:0]  head;
		logic [15:0]  nword;
		logic [7:0]   nptr;
		irap_tgt_state_t r;
		irap_tgt_state_t n;
		r = state_reg;
		n = state_reg;
		// Only the second and third stages feed edge logic
		rise    = r.scl_p[1] & ~r.scl_p[2];
		fall    = ~r.scl_p[1] & r.scl_p[2];
		start_c = r.scl_p[1] & r.scl_p[2] & r.sda_p[2] & ~r.sda_p[1];
		stop_c  = r.scl_p[1] & r.scl_p[2] & ~r.sda_p[2] & r.sda_p[1];
		push    = push_valid & r.ready;
		pop     = 1'b0;
		do_srst = 1'b0;
		word    = {r.whi, r.sh};
		head    = (r.cnt != 2'h0) ? r.mem[r.ri] : 16'h0000;
		nword   = 16'h0000;
		nptr    = r.ptr;
		n.scl_p = {r.scl_p[1:0], bus.scl};
		n.sda_p = {r.sda_p[1:0], bus.sda};
		n.int_p = {r.int_p[0], int_pin};
		n.aux_p = {r.aux_p[0], aux_select_pin};
		n.srst  = 1'b0;
		// Pins count only when their input buffer is enabled
		key_ok = (~r.key[KEY_INT_USE] | (r.pin_buf[PIN_BUF_INT] &
			(r.int_p[1] == r.key[KEY_INT_LVL]))) &
			(~r.key[KEY_AUX_USE] | (r.pin_buf[PIN_BUF_AUX] &
			(r.aux_p[1] == r.key[KEY_AUX_LVL])));

		// Producer side of the two-entry buffer
		if (push) begin
			n.mem[r.wi] = push_data;
			n.wi        = ~r.wi;
		end

		if (start_c) begin
			// Start and repeated start restart the frame
			n.ph   = T_ADDR;
			n.bcnt = 4'hF; // Marks the start's own clock fall
			n.oe   = 1'b0;
			n.widx = 2'h0;
		end else if (stop_c) begin
			n.ph = T_IDLE;
			n.oe = 1'b0;
		end else if (r.ph != T_IDLE && r.ph != T_SKIP) begin
			if (rise) begin
				if (r.bcnt != 4'h8) begin
					n.sh = {r.sh[6:0], r.sda_p[1]};
				end else begin
					n.mack = ~r.sda_p[1];
				end
			end else if (fall) begin
				if (r.bcnt == 4'hF) begin
					// Fall that closes a start carries no bit
					n.bcnt = 4'h0;
				end else if (r.bcnt < 4'h7) begin
					n.bcnt = r.bcnt + 4'h1;
					if (r.ph == T_RD) begin
						n.tx = {r.tx[6:0], 1'b0};
						n.oe = ~r.tx[6];
					end
				end else if (r.bcnt == 4'h7) begin
					// Eighth bit done: decide the acknowledge
					n.bcnt = 4'h8;
					unique case (r.ph)
						T_ADDR: begin
							if (r.sh[7:1] == r.addr) begin
								n.oe = 1'b1;
							end else begin
								n.ph = T_SKIP;
							end
						end
						T_REG: begin
							n.ptr = r.sh;
							n.oe  = 1'b1;
						end
						T_WR: begin
							if (r.widx == 2'h0) begin
								n.whi  = r.sh;
								n.widx = 2'h1;
								n.oe   = 1'b1;
							end else if (r.widx == 2'h1) begin
								n.widx = 2'h2;
								if (r.ptr == REG_SOFT_RST && r.sh[SOFT_RST_BIT])
									do_srst = 1'b1;
								else
									n.oe = 1'b1;
								// Any write other than the key disarms
								n.key_armed = (r.ptr == REG_ADDR_KEY);
								if (r.ptr == REG_ADDR_KEY)
									n.key = word;
								if (r.ptr == REG_PIN_BUF)
									n.pin_buf = word;
								if (r.ptr == REG_BUS_ADDR && r.key_armed && key_ok &&
									word[UNLOCK_MSB:UNLOCK_LSB] == ADDR_UNLOCK)
									n.addr = word[BUS_ADDR_MSB:BUS_ADDR_LSB];
							end else begin
								n.oe = 1'b0;
							end
						end
						T_RD: begin
							// Let the host answer
							n.oe = 1'b0;
						end
						default: begin
							n.oe = 1'b0;
						end
					endcase
				end else begin
					// Ninth bit done: move on
					n.bcnt = 4'h0;
					n.oe   = 1'b0;
					unique case (r.ph)
						T_ADDR: begin
							if (r.sh[0]) begin
								nword = (r.ptr == REG_FIFO) ? head :
									rd_mux(r.ptr, r.addr, r.key, r.pin_buf);
								n.ph   = T_RD;
								n.bidx = 1'b0;
								n.tx   = nword[15:8];
								n.oe   = ~nword[15];
							end else begin
								n.ph = T_REG;
							end
						end
						T_REG: begin
							n.ph   = T_WR;
							n.widx = 2'h0;
						end
						T_WR: begin
							n.ph = T_WR;
						end
						T_RD: begin
							nword = (r.ptr == REG_FIFO) ? head :
								rd_mux(r.ptr, r.addr, r.key, r.pin_buf);
							if (r.bidx == 1'b0) begin
								n.bidx = 1'b1;
								n.tx   = nword[7:0];
							end else begin
								// Word complete, acked or not
								n.bidx = 1'b0;
								if (r.ptr == REG_FIFO) begin
									pop = (r.cnt != 2'h0);
									nword = (r.cnt > 2'h1) ? r.mem[~r.ri] : 16'h0000;
								end else begin
									if (r.ptr != REG_HOLD_LO && r.ptr != REG_HOLD_HI)
										nptr = r.ptr + 8'h01;
									nword = rd_mux(nptr, r.addr, r.key, r.pin_buf);
								end
								n.ptr = nptr;
								n.tx  = nword[15:8];
							end
							if (r.mack) begin
								n.oe = ~n.tx[7];
							end else begin
								n.ph = T_SKIP;
							end
						end
						default: begin
							n.ph = T_SKIP;
						end
					endcase
				end
			end
		end

		// Buffer bookkeeping
		if (pop)
			n.ri = ~r.ri;
		n.cnt   = 2'(r.cnt + {1'b0, push} - {1'b0, pop});
		n.ready = (n.cnt != FIFO_DEPTH);

		// Soft reset acts at once; the frame is then ignored
		if (do_srst) begin
			n.ph        = T_SKIP;
			n.oe        = 1'b0;
			n.addr      = DEF_BUS_ADDR;
			n.key       = KEY_RST;
			n.key_armed = 1'b0;
			n.pin_buf   = PIN_BUF_RST;
			n.wi        = 1'b0;
			n.ri        = 1'b0;
			n.cnt       = 2'h0;
			n.ready     = 1'b1;
			n.srst      = 1'b1;
		end
		state_next = n;
	end

	// ----------------------------------------------------------------
	// Read value for plain registers; unknown ones read zero
	// ----------------------------------------------------------------
	function automatic logic [15:0] rd_mux(
		input logic [7:0]  a,
		input logic [6:0]  ad,
		input logic [15:0] k,
		input logic [15:0] pb
	);
		logic [15:0] v;
		v = 16'h0000;
		if (a == REG_BUS_ADDR)
			v = {8'h00, ad, 1'b0};
		else if (a == REG_ADDR_KEY)
			v = k;
		else if (a == REG_PIN_BUF)
			v = pb;
		return v;
	endfunction

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg           <= '0;
			state_reg.scl_p     <= 3'h7;
			state_reg.sda_p     <= 3'h7;
			state_reg.ph        <= T_IDLE;
			state_reg.addr      <= DEF_BUS_ADDR;
			state_reg.key       <= KEY_RST;
			state_reg.pin_buf   <= PIN_BUF_RST;
			state_reg.ready     <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs; clock line is never driven here
	// ----------------------------------------------------------------
	assign bus.sda_d_o  = 1'b0;
	assign bus.sda_d_oe = state_reg.oe;
	assign push_ready   = state_reg.ready;
	assign soft_reset   = state_reg.srst;
	assign bus_address  = state_reg.addr;

endmodule // irap_target

`default_nettype wire

// >>> tb_i2c_register_access_port.sv
`timescale 1ns/100ps
`default_nettype none

module tb_i2c_register_access_port import irap_pkg::*;;
	logic        clk, rst_n, int_pin, aux_select_pin;
	logic        push_valid, push_ready, soft_reset;
	logic [15:0] push_data, cmd_wdata, rd_data;
	logic [6:0]  bus_address, cmd_dev;
	logic        cmd_valid, cmd_ready, cmd_read;
	logic        rd_valid, rd_ready, done, nack_err;
	logic [7:0]  cmd_reg;
	logic [3:0]  cmd_words;
	logic        last_nack, rst_seen;
	logic [15:0] got[$];
	int          n_fail, checks;

	irap_i2c_if bus_if ();

	irap_target irap_target_i (.clk(clk), .rst_n(rst_n), .bus(bus_if),
		.int_pin(int_pin), .aux_select_pin(aux_select_pin),
		.push_valid(push_valid), .push_data(push_data),
		.push_ready(push_ready), .soft_reset(soft_reset),
		.bus_address(bus_address));

	irap_controller irap_controller_i (.clk(clk), .rst_n(rst_n),
		.bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_read(cmd_read), .cmd_dev(cmd_dev), .cmd_reg(cmd_reg),
		.cmd_wdata(cmd_wdata), .cmd_words(cmd_words),
		.rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data),
		.done(done), .nack_err(nack_err));

	irap_checker irap_checker_i (.clk(clk), .rst_n(rst_n),
		.sda_d_oe(bus_if.sda_d_oe), .scl(bus_if.scl), .sda(bus_if.sda));

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic check(input string what, input logic [15:0] exp,
		input logic [15:0] seen);
		checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One command through the controller; words land in got
	task automatic xfer(input logic rd, input logic [6:0] dev,
		input logic [7:0] rg, input logic [15:0] wd,
		input logic [3:0] n, input int stall);
		int t;
		got.delete();
		@(negedge clk);
		cmd_valid = 1'b1;
		cmd_read = rd;
		cmd_dev = dev;
		cmd_reg = rg;
		cmd_wdata = wd;
		cmd_words = n;
		t = 0;
		while (!cmd_ready && t < 100) begin
			@(negedge clk);
			t++;
		end
		@(negedge clk);
		cmd_valid = 1'b0;
		t = 0;
		// Reader stall checks that no word is lost while held
		while (done !== 1'b1 && t < 4000) begin
			rd_ready = !(rd_valid && stall > 0);
			if (!rd_ready) stall--;
			if (rd_valid && rd_ready) got.push_back(rd_data);
			if (soft_reset === 1'b1) rst_seen = 1'b1;
			@(negedge clk);
			t++;
		end
		rd_ready = 1'b1;
		last_nack = nack_err;
		check("done", 16'h0001, 16'(t < 4000));
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs;
		check("addr", 16'h0064, 16'(bus_address));
		xfer(1'b0, DEF_BUS_ADDR, REG_PIN_BUF, 16'h0022, 4'h1, 0);
		check("ack", 16'h0000, 16'(last_nack));
		xfer(1'b1, DEF_BUS_ADDR, 8'h4E, 16'h0000, 4'h2, 0);
		check("words", 16'h0002, 16'(got.size()));
		check("inc", 16'h0022, got[1]);
		xfer(1'b1, DEF_BUS_ADDR, REG_BUS_ADDR, 16'h0000, 4'h1, 0);
		check("rd09", 16'h00C8, got[0]);
		xfer(1'b0, 7'h65, REG_PIN_BUF, 16'h0000, 4'h1, 0);
		check("other", 16'h0001, 16'(last_nack));
	endtask

	// Fill the buffer until refused, drain past empty
	task automatic t_fifo;
		@(negedge clk);
		push_valid = 1'b1;
		push_data = 16'h1234;
		@(negedge clk);
		push_data = 16'hA5C3;
		@(negedge clk);
		push_valid = 1'b0;
		@(negedge clk);
		check("full", 16'h0000, 16'(push_ready));
		// Pointer must stay below the buffer port, or a word is lost
		xfer(1'b1, DEF_BUS_ADDR, REG_HOLD_LO, 16'h0000, 4'h2, 0);
		check("hold", 16'h0000, got[1]);
		check("kept", 16'h0000, 16'(push_ready));
		xfer(1'b1, DEF_BUS_ADDR, REG_FIFO, 16'h0000, 4'h3, 40);
		check("w0", 16'h1234, got[0]);
		check("w1", 16'hA5C3, got[1]);
		check("w2", 16'h0000, got[2]);
		check("room", 16'h0001, 16'(push_ready));
	endtask

	// Bad level, bad unlock byte, write in between, then good
	task automatic t_addr;
		logic [15:0] v;
		aux_select_pin = 1'b0;
		for (int i = 0; i < 4; i++) begin
			int_pin = (i != 0);
			v = (i == 1) ? 16'hAC54 : 16'hAD54;
			xfer(1'b0, DEF_BUS_ADDR, REG_ADDR_KEY, 16'h0007, 4'h1, 0);
			if (i == 2) xfer(1'b0, DEF_BUS_ADDR, REG_PIN_BUF, 16'h0022, 4'h1, 0);
			xfer(1'b0, DEF_BUS_ADDR, REG_BUS_ADDR, v, 4'h1, 0);
			v = (i == 3) ? 16'h002A : 16'h0064;
			check("newaddr", v, 16'(bus_address));
		end
		xfer(1'b1, 7'h2A, REG_BUS_ADDR, 16'h0000, 4'h1, 0);
		check("rd09", 16'h0054, got[0]);
		xfer(1'b0, DEF_BUS_ADDR, REG_PIN_BUF, 16'h0000, 4'h1, 0);
		check("old", 16'h0001, 16'(last_nack));
	endtask

	// Soft reset is refused on the wire yet takes effect
	task automatic t_reset;
		rst_seen = 1'b0;
		xfer(1'b0, 7'h2A, REG_SOFT_RST, 16'h0001, 4'h1, 0);
		check("srnack", 16'h0001, 16'(last_nack));
		check("pulse", 16'h0001, 16'(rst_seen));
		check("addr", 16'h0064, 16'(bus_address));
		xfer(1'b1, DEF_BUS_ADDR, REG_ADDR_KEY, 16'h0000, 4'h1, 0);
		check("key", 16'h0000, got[0]);
	endtask

	task automatic complete_run;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		rst_n = 1'b0;
		int_pin = 1'b0;
		aux_select_pin = 1'b0;
		push_valid = 1'b0;
		push_data = 16'h0000;
		cmd_valid = 1'b0;
		cmd_read = 1'b0;
		cmd_dev = 7'h00;
		cmd_reg = 8'h00;
		cmd_wdata = 16'h0000;
		cmd_words = 4'h1;
		rd_ready = 1'b1;
		n_fail = 0;
		checks = 0;
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		@(negedge clk);
		t_regs();
		t_fifo();
		t_addr();
		t_reset();
		complete_run();
	end

	// Nearly three times the expected run length, to allow margin
	initial begin
		#6000000;
		n_fail++;
		$display("[FAIL] run expected end seen hang");
		complete_run();
	end
endmodule // tb_i2c_register_access_port

`default_nettype wire
